/* File: core/adc_channel_sequencer_output.sv */
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

module adc_channel_sequencer_output
  import adc_seq_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  input  wire logic        comp_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic [1:0]       mux_sel_o,
  output logic             hold_o,
  output logic [11:0]      dac_code_o,
  output logic             range_x2_o,
  output logic             power_down_o,
  output logic             seq_running_o,
  output logic [1:0]       next_chan_o
);

  link_state_type lk_r;
  link_state_type lk_nxt;
  sys_state_type  sy_r;
  sys_state_type  sy_nxt;
  logic           upd;
  logic           cs_fall;
  logic [11:0]    cw;
  logic [1:0]     cw_seq;
  logic [1:0]     cw_addr;

  // step through the programmed sequence with wrap
  function automatic logic [1:0] step_chan(input logic [1:0] cur,
                                           input logic [1:0] fin);
    step_chan = (cur == fin) ? `CHAN_FIRST : cur + 2'h1;
  endfunction

  // sign flip on the result msb gives twos complement
  function automatic logic out_bit(input logic [11:0] res,
                                   input logic [3:0]  idx,
                                   input logic        coding_bin);
    out_bit = res[idx] ^ ((idx == `RES_MSB) & ~coding_bin);
  endfunction

  // ---------------------------------------------------------------
  // serial clock domain; chip select high ends the frame at once,
  // since the serial clock may stop between frames
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] sbit;
    logic [3:0] obit;
    sbit   = 4'(`SAR_BIT_BASE - lk_r.cnt);
    obit   = 4'(`OUT_BIT_BASE - lk_r.cnt);
    lk_nxt = lk_r;
    if (lk_r.cnt != `EDGE_END) begin
      lk_nxt.cnt = lk_r.cnt + 5'h01;
    end
    if (lk_r.cnt <= `EDGE_CW_DONE) begin
      lk_nxt.shin = {lk_r.shin[10:0], din_i};
    end
    if (lk_r.cnt == `EDGE_CW_DONE) begin
      lk_nxt.done = 1'b1;
    end
    case (lk_r.cnt)
      `EDGE_CAPTURE: begin
        // settings are quiet here: the system side only moves them
        // after the previous frame's control word arrived
        // sample and start
        lk_nxt.chan       = sy_r.conv_chan;
        lk_nxt.coding_bin = sy_r.coding_bin;
        lk_nxt.range_ref  = sy_r.range_ref;
        lk_nxt.hold       = 1'b1;
        lk_nxt.dout       = 1'b0;
      end
      `EDGE_TRIAL: begin
        lk_nxt.dout = lk_r.chan[1];
        lk_nxt.dac  = `DAC_TRIAL;
      end
      `EDGE_TAIL: begin
        lk_nxt.dout = 1'b0;
      end
      default: begin
        if (lk_r.cnt == `EDGE_ADDR_LO) begin
          lk_nxt.dout = lk_r.chan[0];
        end else if (lk_r.cnt < `EDGE_TAIL) begin
          lk_nxt.dout = out_bit(lk_r.res, obit, lk_r.coding_bin);
        end
        if (lk_r.cnt >= `EDGE_ADDR_LO && lk_r.cnt <= `EDGE_SAR_LAST) begin
          // one result bit per serial clock
          lk_nxt.res[sbit] = comp_i;
          lk_nxt.dac[sbit] = comp_i;
          if (sbit != 4'h0) begin
            lk_nxt.dac[sbit - 4'h1] = 1'b1;
          end
        end
        if (lk_r.cnt == `EDGE_SAR_LAST) begin
          lk_nxt.hold = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ---------------------------------------------------------------
  // system clock domain: control register and sequencer
  // ---------------------------------------------------------------
  // the control word holds still from its twelfth edge to the end of
  // the frame, so it is read only behind the synchronised done flag
  assign cw      = lk_r.shin;
  assign cw_seq  = {cw[`CW_SEQ_HI], cw[`CW_SEQ_LO]};
  assign cw_addr = {cw[`CW_ADDR_HI], cw[`CW_ADDR_LO]};
  assign upd     = sy_r.dn_s2 & ~sy_r.dn_s3;
  assign cs_fall = sy_r.cs_s3 & ~sy_r.cs_s2;

  always_comb begin
    sy_nxt       = sy_r;
    sy_nxt.cs_s1 = cs_n_i;
    sy_nxt.cs_s2 = sy_r.cs_s1;
    sy_nxt.cs_s3 = sy_r.cs_s2;
    sy_nxt.dn_s1 = lk_r.done;
    sy_nxt.dn_s2 = sy_r.dn_s1;
    sy_nxt.dn_s3 = sy_r.dn_s2;
    if (cs_fall) begin
      sy_nxt.asleep = 1'b0;
    end
    if (upd) begin
      if (cw[`CW_WRITE]) begin
        sy_nxt.coding_bin = cw[`CW_CODING];
        sy_nxt.range_ref  = cw[`CW_RANGE];
        sy_nxt.pm         = {cw[`CW_PM_HI], cw[`CW_PM_LO]};
        case (cw_seq)
          `SEQ_START: begin
            sy_nxt.mode       = SEQ_RUN;
            sy_nxt.final_chan = cw_addr;
            sy_nxt.conv_chan  = `CHAN_FIRST;
          end
          `SEQ_KEEP: begin
            if (sy_r.mode == SEQ_RUN) begin
              sy_nxt.conv_chan = step_chan(sy_r.conv_chan,
                                           sy_r.final_chan);
            end else begin
              sy_nxt.conv_chan = cw_addr;
            end
          end
          default: begin
            sy_nxt.mode      = SEQ_OFF;
            sy_nxt.conv_chan = cw_addr;
          end
        endcase
      end else if (sy_r.mode == SEQ_RUN) begin
        sy_nxt.conv_chan = step_chan(sy_r.conv_chan, sy_r.final_chan);
      end
      // auto shutdown sleeps once each control word is in, before the conversion ends; set wins over wake
      if (sy_nxt.pm == `PM_AUTO_OFF) begin
        sy_nxt.asleep = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sy_r            <= '0;
      sy_r.pm         <= `RST_PM;
      sy_r.range_ref  <= `RST_RANGE;
      sy_r.coding_bin <= `RST_CODING;
      sy_r.conv_chan  <= `RST_CHAN;
      sy_r.cs_s1      <= 1'b1;
      sy_r.cs_s2      <= 1'b1;
      sy_r.cs_s3      <= 1'b1;
      sy_r.mode       <= SEQ_OFF;
    end else if (ce_i) begin
      sy_r <= sy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dout_o        = lk_r.dout;
  assign dout_oe_o     = ~cs_n_i;
  assign mux_sel_o     = lk_r.chan;
  assign hold_o        = lk_r.hold;
  assign dac_code_o    = lk_r.dac;
  assign range_x2_o    = ~lk_r.range_ref;
  // pattern 00 is left to the host
  assign power_down_o  = (sy_r.pm == `PM_FULL_OFF) |
                         ((sy_r.pm == `PM_AUTO_OFF) & sy_r.asleep);
  assign seq_running_o = (sy_r.mode == SEQ_RUN);
  assign next_chan_o   = sy_r.conv_chan;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_update;
    ce_i && upd;
  endsequence

  sequence s_header;
    (lk_r.dout == 1'b0) ##1 (lk_r.dout == lk_r.chan[1])
      ##1 (lk_r.dout == lk_r.chan[0]);
  endsequence

  property p_header;
    @(posedge sclk_i) disable iff (cs_n_i)
      (lk_r.cnt == `EDGE_TRIAL) |-> s_header;
  endproperty
  a_header: assert property (p_header)
    else $error("result word header wrong");

  property p_sign;
    @(posedge sclk_i) disable iff (cs_n_i)
      (lk_r.cnt == `EDGE_MSB_OUT)
        |-> lk_r.dout == (lk_r.res[11] ^ ~lk_r.coding_bin);
  endproperty
  a_sign: assert property (p_sign)
    else $error("result msb coding wrong");

  property p_track;
    @(posedge sclk_i) disable iff (cs_n_i)
      (lk_r.cnt == `EDGE_SAR_LAST) |=> !lk_r.hold && lk_r.dac == lk_r.res;
  endproperty
  a_track: assert property (p_track)
    else $error("conversion not done by fourteenth edge");

  property p_capture;
    @(posedge sclk_i) disable iff (cs_n_i)
      (lk_r.cnt == `EDGE_CAPTURE) |=> lk_r.chan == $past(sy_r.conv_chan)
        && lk_r.hold;
  endproperty
  a_capture: assert property (p_capture)
    else $error("channel not captured at frame start");

  property p_seq_start;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_update ##0 (cw[`CW_WRITE] && cw_seq == `SEQ_START)
        |=> seq_running_o && next_chan_o == `CHAN_FIRST;
  endproperty
  a_seq_start: assert property (p_seq_start)
    else $error("sequence did not start at channel 0");

  property p_seq_step;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_update ##0 (!cw[`CW_WRITE] && seq_running_o)
        |=> next_chan_o == step_chan($past(sy_r.conv_chan),
                                     $past(sy_r.final_chan));
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequence step or wrap wrong");

  property p_seq_keep;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_update ##0 (cw[`CW_WRITE] && cw_seq == `SEQ_KEEP && seq_running_o)
        |=> seq_running_o && $stable(sy_r.final_chan);
  endproperty
  a_seq_keep: assert property (p_seq_keep)
    else $error("sequence broken by keep write");

  property p_seq_end;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_update ##0 (cw[`CW_WRITE] && !cw[`CW_SEQ_HI])
        |=> !seq_running_o && next_chan_o == $past(cw_addr);
  endproperty
  a_seq_end: assert property (p_seq_end)
    else $error("sequence not ended or wrong channel");

  property p_settings;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_update ##0 cw[`CW_WRITE] |=> sy_r.coding_bin == $past(cw[`CW_CODING])
        && sy_r.range_ref == $past(cw[`CW_RANGE]);
  endproperty
  a_settings: assert property (p_settings)
    else $error("coding or range not loaded");

  property p_full_off;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (sy_r.pm == `PM_FULL_OFF) |-> power_down_o;
  endproperty
  a_full_off: assert property (p_full_off)
    else $error("full shutdown not shown");

  property p_next_conv;
    @(posedge sclk_i) disable iff (cs_n_i)
      (lk_r.cnt == `EDGE_CAPTURE)
        |=> lk_r.coding_bin == $past(sy_r.coding_bin)
          && lk_r.range_ref == $past(sy_r.range_ref);
  endproperty
  a_next_conv: assert property (p_next_conv)
    else $error("coding or range not taken at frame start");

  property p_span_held;
    @(posedge sclk_i) disable iff (cs_n_i)
      (lk_r.cnt > `EDGE_TRIAL)
        |-> $stable(range_x2_o) && $stable(mux_sel_o);
  endproperty
  a_span_held: assert property (p_span_held)
    else $error("span or channel moved during conversion");

  property p_final_chan;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      s_update ##0 (cw[`CW_WRITE] && cw_seq == `SEQ_START)
        |=> sy_r.final_chan == $past(cw_addr);
  endproperty
  a_final_chan: assert property (p_final_chan)
    else $error("final channel not loaded");

  property p_wake;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (ce_i && cs_fall && !upd) |=> !sy_r.asleep;
  endproperty
  a_wake: assert property (p_wake)
    else $error("auto shutdown did not wake on chip select");

endmodule // adc_channel_sequencer_output

/* File: core/adc_seq_pkg.sv */
package adc_seq_pkg;

  typedef enum logic {SEQ_OFF, SEQ_RUN} seq_mode_type;

  // serial clock side, cleared while chip select is high
  typedef struct packed {
    logic [4:0]  cnt;
    logic [1:0]  chan;
    logic        coding_bin;
    logic        range_ref;
    logic        hold;
    logic [11:0] res;
    logic [11:0] dac;
    logic [11:0] shin;
    logic        dout;
    logic        done;
  } link_state_type;

  // system clock side
  typedef struct packed {
    logic         cs_s1;
    logic         cs_s2;
    logic         cs_s3;
    logic         dn_s1;
    logic         dn_s2;
    logic         dn_s3;
    logic [1:0]   pm;
    logic         range_ref;
    logic         coding_bin;
    logic [1:0]   final_chan;
    logic [1:0]   conv_chan;
    seq_mode_type mode;
    logic         asleep;
  } sys_state_type;

endpackage

/* File: core/adc_seq_regs.svh */
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// control word bit positions, first bit shifted in is the write bit
`define CW_BITS      12
`define CW_WRITE     11
`define CW_SEQ_HI    10
`define CW_ADDR_HI   7
`define CW_ADDR_LO   6
`define CW_PM_HI     5
`define CW_PM_LO     4
`define CW_SEQ_LO    3
`define CW_RANGE     1
`define CW_CODING    0

// result word framing
`define RES_BITS     12
`define RES_MSB      4'hb
`define DAC_TRIAL    12'h800

// sequence bit patterns
`define SEQ_START    2'h3
`define SEQ_KEEP     2'h2

// power mode patterns
`define PM_NORMAL    2'h3
`define PM_FULL_OFF  2'h2
`define PM_AUTO_OFF  2'h1

// reset values of the control settings
`define RST_PM       2'h3
`define RST_RANGE    1'h0
`define RST_CODING   1'h0
`define RST_CHAN     2'h0
`define CHAN_FIRST   2'h0

// conversion timing in serial clock edges
`define CONV_TIME_NS   800
`define CONV_SCLK_MHZ  20
`define CONV_SCLK_CYC  ((`CONV_TIME_NS * `CONV_SCLK_MHZ) / 1000)
`define EDGE_CAPTURE   5'h00
`define EDGE_TRIAL     5'h01
`define EDGE_ADDR_LO   5'h02
`define EDGE_MSB_OUT   5'h04
`define EDGE_SAR_LAST  5'h0d
`define EDGE_CW_DONE   5'h0b
`define EDGE_TAIL      5'h0f
`define EDGE_END       5'(`CONV_SCLK_CYC)
`define SAR_BIT_BASE   5'h0d
`define OUT_BIT_BASE   5'h0e

`endif

/* File: verification/adc_channel_sequencer_output_test.sv */
`timescale 1ns/1ps
`include "adc_seq_regs.svh"

module adc_channel_sequencer_output_test;
  import adc_seq_pkg::*;
  logic        sys_clk_i;
  logic        sys_rst_i;
  logic        ce_i;
  logic        sclk_i;
  logic        cs_n_i;
  logic        din_i;
  logic        comp_i;
  logic        dout_o;
  logic        dout_oe_o;
  logic [1:0]  mux_sel_o;
  logic        hold_o;
  logic [11:0] dac_code_o;
  logic        range_x2_o;
  logic        power_down_o;
  logic        seq_running_o;
  logic [1:0]  next_chan_o;
  logic [12:0] ana [4];
  logic [15:0] exp_q [$];
  logic [1:0]  m_ch;
  logic [1:0]  m_fin;
  logic [1:0]  m_pm;
  logic        m_seq;
  logic        m_cod;
  logic        m_rng;
  int          mismatches;
  int          cmp_count;

  adc_channel_sequencer_output dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .comp_i(comp_i),
    .dout_o(dout_o), .dout_oe_o(dout_oe_o), .mux_sel_o(mux_sel_o),
    .hold_o(hold_o), .dac_code_o(dac_code_o), .range_x2_o(range_x2_o),
    .power_down_o(power_down_o), .seq_running_o(seq_running_o),
    .next_chan_o(next_chan_o));

  adc_host_model host (
    .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));

  // analog inputs counted in single-span steps; double span halves resolution
  assign comp_i = range_x2_o ? (ana[mux_sel_o] >= {dac_code_o, 1'b0})
                             : (ana[mux_sel_o] >= {1'b0, dac_code_o});

  initial begin
    sys_clk_i = 1'b0;
  end
  always #12.5 sys_clk_i = ~sys_clk_i;

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_word(input logic [1:0] ch);
    logic [11:0] c;
    c = m_rng ? ((ana[ch] > 13'h0fff) ? 12'hfff : ana[ch][11:0])
              : ana[ch][12:1];
    if (!m_cod) begin
      c[11] = ~c[11];
    end
    return {2'b00, ch, c};
  endfunction

  function automatic logic [11:0] mk(input logic [1:0] sq,
    input logic [1:0] ch, input logic [1:0] pm, input logic rng,
    input logic cod);
    return {1'b1, sq[1], 2'b00, ch, pm, sq[0], 1'b0, rng, cod};
  endfunction

  // reference of the settings, advanced only by complete control words
  task automatic xfer(input logic [11:0] cw, input int edges);
    if (edges == 16 && m_pm == `PM_NORMAL) begin
      exp_q.push_back(exp_word(m_ch));
    end
    host.do_frame(cw, edges);
    if (edges >= 12 && cw[`CW_WRITE]) begin
      m_cod = cw[`CW_CODING];
      m_rng = cw[`CW_RANGE];
      m_pm = cw[`CW_PM_HI:`CW_PM_LO];
      if ({cw[`CW_SEQ_HI], cw[`CW_SEQ_LO]} == `SEQ_START) begin
        m_seq = 1'b1;
        m_fin = cw[`CW_ADDR_HI:`CW_ADDR_LO];
        m_ch = `CHAN_FIRST;
      end else if ({cw[`CW_SEQ_HI], cw[`CW_SEQ_LO]} == `SEQ_KEEP && m_seq)
      begin
        m_ch = (m_ch == m_fin) ? 2'h0 : m_ch + 2'h1;
      end else begin
        m_seq = 1'b0;
        m_ch = cw[`CW_ADDR_HI:`CW_ADDR_LO];
      end
    end else if (edges >= 12 && m_seq) begin
      m_ch = (m_ch == m_fin) ? 2'h0 : m_ch + 2'h1;
    end
    check("next channel", 16'(m_ch), 16'(next_chan_o));
    check("sequencer on", 16'(m_seq), 16'(seq_running_o));
    check("power down", 16'(m_pm != `PM_NORMAL), 16'(power_down_o));
    check("dout enable idle", 16'h0, 16'(dout_oe_o));
    check("hold idle", 16'h0, 16'(hold_o));
  endtask

  initial begin
    forever begin
      @(host.frame_done);
      if (exp_q.size() > 0) begin
        check("result word", exp_q.pop_front(), host.word);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    $display("wait limit reached");
    stop_test();
  end

  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    m_ch = `RST_CHAN;
    m_fin = 2'h0;
    m_pm = `RST_PM;
    m_seq = 1'b0;
    m_cod = `RST_CODING;
    m_rng = `RST_RANGE;
    void'($urandom(18));
    for (int i = 0; i < 4; i++) begin
      ana[i] = 13'($urandom);
    end
    repeat (12) @(posedge sys_clk_i);
    #2 sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #2;
    // write bit 0 keeps the reset settings
    xfer(12'h000, 16);
    $display("end of test reset");
    for (int i = 0; i < 4; i++) begin
      xfer(mk(2'h0, 2'(i), 2'h3, i[1], i[0]), 16);
    end
    ana[0] = 13'h1000;
    xfer(mk(2'h0, 2'h0, 2'h3, 1'b0, 1'b0), 16);
    xfer(12'h000, 16);
    for (int i = 0; i < 6; i++) begin
      xfer(mk(2'h1, 2'($urandom), 2'h3, 1'($urandom), 1'($urandom)), 16);
    end
    $display("end of test direct");
    xfer(mk(2'h3, 2'h2, 2'h3, 1'b1, 1'b1), 16);
    repeat (5) xfer(12'h000, 16);
    xfer(mk(2'h2, 2'h3, 2'h3, 1'b0, 1'b0), 16);
    repeat (2) xfer(12'h000, 16);
    xfer(mk(2'h0, 2'h3, 2'h3, 1'b1, 1'b1), 8);
    xfer(mk(2'h0, 2'h3, 2'h3, 1'b1, 1'b1), 16);
    xfer(12'h000, 16);
    $display("end of test sequencer");
    xfer(mk(2'h0, 2'h1, 2'h2, 1'b1, 1'b1), 16);
    xfer(mk(2'h0, 2'h1, 2'h1, 1'b1, 1'b1), 16);
    xfer(12'h000, 16);
    xfer(mk(2'h0, 2'h2, 2'h3, 1'b1, 1'b1), 16);
    xfer(12'h000, 16);
    $display("end of test power");
    stop_test();
  end
endmodule // adc_channel_sequencer_output_test

/* File: verification/adc_host_model.sv */
`timescale 1ns/1ps

// serial host: frames chip select, serial clock and data in
module adc_host_model (
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        din_o,
  input  wire logic   dout_i
);
  logic [15:0] word;
  event        frame_done;

  // clock idles high and stands still between frames
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  task automatic do_frame(input logic [11:0] cw, input int edges);
    cs_n_o = 1'b0;
    #24;
    word[15] = dout_i;
    for (int n = 1; n <= edges; n++) begin
      sclk_o = 1'b0;
      din_o = (n <= 12) ? cw[12-n] : ~din_o;
      #24;
      sclk_o = 1'b1;
      #24;
      if (n <= 15) begin
        word[15-n] = dout_i;
      end
    end
    cs_n_o = 1'b1;
    ->frame_done;
    // released line must not keep its last level
    din_o = ~din_o;
    #300;
  endtask
endmodule // adc_host_model
